//--- pkg/rbhw_pkg.sv
// constants for the relay board heater watchdog
// Behaviour
// - decode host bus commands, drive relays, switches
// - watchdog indicator changes only by host command
// - timeout watches the indicator drive itself
// - indicator static 30 seconds forces heaters off
// - indicators reset unlit; heater indicator tracks heating
package rbhw_pkg;
	// bus address of this board; value arbitrary
	localparam logic [6:0] C_DEV_ADDR = 7'h20;
	localparam int C_RELAY_W = 8;
	localparam int C_HEATER_W = 4;
	localparam int C_AUX_W = 3;
	// bank pointer values, first data byte of a write selects one
	localparam logic [1:0] C_BANK_RELAY = 2'h0;
	localparam logic [1:0] C_BANK_HEATER = 2'h1;
	localparam logic [1:0] C_BANK_IND = 2'h2;
	localparam logic [1:0] C_BANK_NONE = 2'h3;
	// field positions in the indicator bank
	localparam int C_IND_WD_BIT = 0;
	localparam int C_IND_AUX_LSB = 1;
	// bit counter value after a full byte
	localparam logic [3:0] C_BITS_BYTE = 4'h8;
	// timing
	localparam int C_CLK_NS = 50;
	localparam int C_TICK_NS = 1000000;
	localparam int C_TICK_CYCLES = C_TICK_NS / C_CLK_NS;
	localparam int C_WD_TIMEOUT_S = 30;
	localparam int C_TICKS_PER_S = 1000;
	localparam int C_WD_TIMEOUT_TICKS = C_WD_TIMEOUT_S * C_TICKS_PER_S;
	localparam int C_TICK_W = 15;
	localparam int C_WD_CNT_W = 15;
	typedef enum logic [5:0] {
		RX_IDLE = 6'h01,
		RX_ADDR = 6'h02,
		RX_AACK = 6'h04,
		RX_DATA = 6'h08,
		RX_DACK = 6'h10,
		RX_SKIP = 6'h20
	} rbhw_rx_e;
endpackage : rbhw_pkg

//--- logic/rbhw_wdog.sv
// watchdog timer on the watchdog indicator level
`timescale 1ns/10ps
module rbhw_wdog
	import rbhw_pkg::*;
#(
	parameter int P_TICK_CYCLES = C_TICK_CYCLES,
	parameter int P_TIMEOUT_TICKS = C_WD_TIMEOUT_TICKS
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_level,
	output logic o_shutdown
);
	localparam logic [C_TICK_W-1:0] C_TICK_LAST =
		C_TICK_W'(P_TICK_CYCLES - 1);
	localparam logic [C_WD_CNT_W-1:0] C_CNT_LAST =
		C_WD_CNT_W'(P_TIMEOUT_TICKS - 1);

	logic level_prev_reg, level_prev_next;
	logic [C_TICK_W-1:0] tick_reg, tick_next;
	logic [C_WD_CNT_W-1:0] cnt_reg, cnt_next;
	logic shut_reg, shut_next;
	logic change;
	logic tick;

	always_comb begin
		level_prev_next = i_level;
		change = i_level ^ level_prev_reg;
		tick = (tick_reg == C_TICK_LAST);
		tick_next = tick ? '0 : tick_reg + 1'b1;
		cnt_next = cnt_reg;
		shut_next = shut_reg;
		if (change) begin
			// any edge restarts the full window and lifts a shutdown
			tick_next = '0;
			cnt_next = '0;
			shut_next = 1'b0;
		end else if (tick && !shut_reg) begin
			if (cnt_reg == C_CNT_LAST) begin
				shut_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			level_prev_reg <= 1'b0;
			tick_reg <= '0;
			cnt_reg <= '0;
			shut_reg <= 1'b0;
		end else begin
			level_prev_reg <= level_prev_next;
			tick_reg <= tick_next;
			cnt_reg <= cnt_next;
			shut_reg <= shut_next;
		end
	end

	assign o_shutdown = shut_reg;
endmodule : rbhw_wdog

//--- logic/rbhw_top.sv
// relay board: bus command slave, output banks and heater interlock
`timescale 1ns/10ps
module rbhw_top
	import rbhw_pkg::*;
#(
	parameter int P_TICK_CYCLES = C_TICK_CYCLES,
	parameter int P_TIMEOUT_TICKS = C_WD_TIMEOUT_TICKS
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic [C_RELAY_W-1:0] o_relay,
	output logic [C_HEATER_W-1:0] o_heater,
	output logic o_heater_indicator,
	output logic o_watchdog_indicator,
	output logic [C_AUX_W-1:0] o_aux_indicator,
	output logic o_wd_shutdown
);
	// pin synchronisers
	logic scl_meta_reg, scl_sync_reg, sda_meta_reg, sda_sync_reg;
	logic scl_prev_reg, sda_prev_reg;

	// bus receiver state
	rbhw_rx_e rx_state_reg, rx_state_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic sda_oe_reg, sda_oe_next;
	logic first_reg, first_next;
	logic byte_valid;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// output banks
	logic [1:0] bank_reg, bank_next;
	logic [C_RELAY_W-1:0] relay_reg, relay_next;
	logic [C_HEATER_W-1:0] heater_cmd_reg, heater_cmd_next;
	logic [C_HEATER_W-1:0] heater_reg, heater_next;
	logic heat_ind_reg, heat_ind_next;
	logic wd_ind_reg, wd_ind_next;
	logic [C_AUX_W-1:0] aux_reg, aux_next;
	logic wd_shutdown;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_meta_reg <= i_scl;
			scl_sync_reg <= scl_meta_reg;
			sda_meta_reg <= i_sda;
			sda_sync_reg <= sda_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	// both lines share the same sync delay, so start and stop keep
	// their order against the clock line
	always_comb begin
		scl_rise = scl_sync_reg & ~scl_prev_reg;
		scl_fall = ~scl_sync_reg & scl_prev_reg;
		bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg &
			~sda_sync_reg;
		bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
			sda_sync_reg;
	end

	always_comb begin
		rx_state_next = rx_state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		sda_oe_next = sda_oe_reg;
		first_next = first_reg;
		byte_valid = 1'b0;
		if (bus_start) begin
			// repeated start also lands here
			rx_state_next = RX_ADDR;
			bit_cnt_next = '0;
			sda_oe_next = 1'b0;
			first_next = 1'b1;
		end else if (bus_stop) begin
			rx_state_next = RX_IDLE;
			sda_oe_next = 1'b0;
		end else begin
			unique case (rx_state_reg)
				RX_IDLE, RX_SKIP: begin
				end
				RX_ADDR: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_sync_reg};
						bit_cnt_next = bit_cnt_reg + 1'b1;
					end else if (scl_fall && bit_cnt_reg == C_BITS_BYTE) begin
						// only writes to our address are acknowledged
						if (shift_reg[7:1] == C_DEV_ADDR && !shift_reg[0]) begin
							sda_oe_next = 1'b1;
							rx_state_next = RX_AACK;
						end else begin
							rx_state_next = RX_SKIP;
						end
					end
				end
				RX_AACK, RX_DACK: begin
					if (scl_fall) begin
						sda_oe_next = 1'b0;
						bit_cnt_next = '0;
						rx_state_next = RX_DATA;
					end
				end
				RX_DATA: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_sync_reg};
						bit_cnt_next = bit_cnt_reg + 1'b1;
					end else if (scl_fall && bit_cnt_reg == C_BITS_BYTE) begin
						byte_valid = 1'b1;
						first_next = 1'b0;
						sda_oe_next = 1'b1;
						rx_state_next = RX_DACK;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			rx_state_reg <= RX_IDLE;
			bit_cnt_reg <= '0;
			shift_reg <= '0;
			sda_oe_reg <= 1'b0;
			first_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			sda_oe_reg <= sda_oe_next;
			first_reg <= first_next;
		end
	end

	// command decode: pointer byte, then bank data with auto-increment
	always_comb begin
		bank_next = bank_reg;
		relay_next = relay_reg;
		heater_cmd_next = heater_cmd_reg;
		wd_ind_next = wd_ind_reg;
		aux_next = aux_reg;
		if (byte_valid) begin
			if (first_reg) begin
				bank_next = shift_reg[1:0];
			end else begin
				bank_next = bank_reg + 1'b1;
				unique case (bank_reg)
					C_BANK_RELAY: relay_next = shift_reg;
					C_BANK_HEATER: begin
						heater_cmd_next = shift_reg[C_HEATER_W-1:0];
					end
					C_BANK_IND: begin
						// nothing local ever touches this bit
						wd_ind_next = shift_reg[C_IND_WD_BIT];
						aux_next = shift_reg[C_IND_AUX_LSB +: C_AUX_W];
					end
					C_BANK_NONE: begin
					end
				endcase
			end
		end
	end

	// heaters gated one cycle after the interlock; indicator tracks drive
	always_comb begin
		heater_next = wd_shutdown ? '0 : heater_cmd_reg;
		heat_ind_next = |heater_next;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			bank_reg <= C_BANK_RELAY;
			relay_reg <= '0;
			heater_cmd_reg <= '0;
			heater_reg <= '0;
			heat_ind_reg <= 1'b0;
			wd_ind_reg <= 1'b0;
			aux_reg <= '0;
		end else begin
			bank_reg <= bank_next;
			relay_reg <= relay_next;
			heater_cmd_reg <= heater_cmd_next;
			heater_reg <= heater_next;
			heat_ind_reg <= heat_ind_next;
			wd_ind_reg <= wd_ind_next;
			aux_reg <= aux_next;
		end
	end

	// the timer watches the driven indicator register, not a command copy
	rbhw_wdog #(
		.P_TICK_CYCLES(P_TICK_CYCLES),
		.P_TIMEOUT_TICKS(P_TIMEOUT_TICKS)
	) u_wdog (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_level(wd_ind_reg),
		.o_shutdown(wd_shutdown)
	);

	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_reg;
	assign o_relay = relay_reg;
	assign o_heater = heater_reg;
	assign o_heater_indicator = heat_ind_reg;
	assign o_watchdog_indicator = wd_ind_reg;
	assign o_aux_indicator = aux_reg;
	assign o_wd_shutdown = wd_shutdown;
endmodule : rbhw_top

//--- dv/rbhw_host.sv
// host model: bus master writing board commands
`timescale 1ns/10ps
module rbhw_host (
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : wt
	task automatic start();
		o_sda = 1'b0;
		wt(5);
		o_scl = 1'b0;
	endtask : start
	// msb first; ninth clock released so pull-up shows unless acked
	task automatic put(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			o_sda = (i < 0) ? 1'b1 : b[i];
			wt(5);
			o_scl = 1'b1;
			wt(5);
			ack = ~i_sda;
			o_scl = 1'b0;
		end
	endtask : put
	task automatic stop();
		o_sda = 1'b0;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		o_sda = 1'b1;
		wt(10);
	endtask : stop
endmodule : rbhw_host

//--- dv/rbhw_assertions.sv
// port checker for the relay board heater watchdog
`timescale 1ns/10ps
module rbhw_checker
	import rbhw_pkg::*;
#(
	parameter int P_TICK_CYCLES = C_TICK_CYCLES,
	parameter int P_TIMEOUT_TICKS = C_WD_TIMEOUT_TICKS
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic o_sda_oe,
	input wire logic [C_RELAY_W-1:0] o_relay,
	input wire logic [C_HEATER_W-1:0] o_heater,
	input wire logic o_heater_indicator,
	input wire logic o_watchdog_indicator,
	input wire logic o_wd_shutdown
);
	localparam int LIM = P_TICK_CYCLES * P_TIMEOUT_TICKS;
	int cnt_reg;
	int cnt_next;
	logic prev_reg;
	logic prev_next;
	// cycles since the indicator last moved
	always_comb begin
		prev_next = o_watchdog_indicator;
		cnt_next = (o_watchdog_indicator != prev_reg) ? 0 : cnt_reg + 1;
		if (!i_resetn)
			cnt_next = 0;
	end
	always_ff @(posedge i_mclk) begin
		cnt_reg <= cnt_next;
		prev_reg <= prev_next;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	wd_quiet_a: assert property (cnt_reg > 3 && cnt_reg < LIM - 3
		|-> !o_wd_shutdown) else $error("early shutdown");
	wd_trip_a: assert property (cnt_reg > LIM + 3
		|-> o_wd_shutdown) else $error("no shutdown");
	// the indicator move is seen one cycle before the shutdown drops
	wd_hold_a: assert property (o_wd_shutdown &&
		$stable(o_watchdog_indicator) |=> o_wd_shutdown)
		else $error("shutdown dropped");
	wd_clear_a: assert property (o_wd_shutdown &&
		$changed(o_watchdog_indicator) |-> ##[1:3] !o_wd_shutdown)
		else $error("shutdown stuck");
	heat_off_a: assert property (o_wd_shutdown [*2]
		|-> o_heater == '0) else $error("heater on in shutdown");
	heat_ind_a: assert property (
		o_heater_indicator == (o_heater != '0)) else $error("heater lamp");
	// bank write and data ack are registered on the same edge
	wd_src_a: assert property ($changed(o_watchdog_indicator)
		|-> o_sda_oe) else $error("indicator moved alone");
	relay_src_a: assert property ($changed(o_relay)
		|-> o_sda_oe) else $error("relay moved alone");
	ack_low_a: assert property ($changed(o_sda_oe)
		|-> !i_scl) else $error("ack moved with clock high");
endmodule : rbhw_checker
bind rbhw_top rbhw_checker #(.P_TICK_CYCLES(P_TICK_CYCLES),
	.P_TIMEOUT_TICKS(P_TIMEOUT_TICKS)) u_chk (.i_mclk, .i_resetn, .i_scl,
	.o_sda_oe, .o_relay, .o_heater, .o_heater_indicator,
	.o_watchdog_indicator, .o_wd_shutdown);

//--- dv/rbhw_bench.sv
// bench for the relay board heater watchdog
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: mismatch", $time); end end
module rbhw_bench;
	logic clk, rstn, scl, hsda, sda, oe, hind, wind, shut, ack;
	logic [7:0] relay;
	logic [3:0] heat;
	logic [2:0] aux;
	int n_errors = 0;
	int num_checks = 0;
	// open-drain data line, pulled up
	assign sda = hsda & ~oe;
	rbhw_top #(.P_TICK_CYCLES(10), .P_TIMEOUT_TICKS(100)) DUT (
		.i_mclk(clk), .i_resetn(rstn), .i_scl(scl), .i_sda(sda),
		.o_sda_out(), .o_sda_oe(oe), .o_relay(relay), .o_heater(heat),
		.o_heater_indicator(hind), .o_watchdog_indicator(wind),
		.o_aux_indicator(aux), .o_wd_shutdown(shut));
	rbhw_host host (.i_mclk(clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		host.start();
		host.put(8'h40, ack);
		`CHK(ack, 1'b1)
		host.put(p, ack);
		host.put(d, ack);
		`CHK(ack, 1'b1)
		host.stop();
	endtask : wr
	// indicator changes spaced 885 cycles apart, inside the 1000-cycle timeout
	task automatic t_cmds();
		wr(8'h02, 8'h01);
		`CHK(wind, 1'b1)
		wr(8'h01, 8'h05);
		`CHK({hind, heat}, 5'h15)
		wr(8'h00, 8'ha5);
		`CHK(relay, 8'ha5)
		wr(8'h02, 8'h0e);
		`CHK({aux, wind, shut}, 5'h1c)
	endtask : t_cmds
	task automatic t_refuse();
		for (int i = 0; i < 2; i++) begin
			host.start();
			host.put(i ? 8'h41 : 8'h42, ack);
			`CHK(ack, 1'b0)
			host.put(8'h00, ack);
			host.put(8'h3c, ack);
			host.stop();
			`CHK(relay, 8'ha5)
		end
		// spare bank is acked but must leave every output alone
		wr(8'h03, 8'hff);
		`CHK({relay, heat, aux, wind}, 16'ha55e)
	endtask : t_refuse
	task automatic t_trip();
		repeat (1100) @(negedge clk);
		`CHK({shut, hind, heat, wind}, 7'h40)
		wr(8'h01, 8'h03);
		`CHK(heat, 4'h0)
		wr(8'h02, 8'h01);
		`CHK({shut, hind, heat}, 6'h13)
		wr(8'h01, 8'h00);
		`CHK(hind, 1'b0)
	endtask : t_trip
	initial begin
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		`CHK({relay, heat, hind, wind, aux, shut, oe}, 19'h0_0000)
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		t_cmds();
		t_refuse();
		t_trip();
		complete_run();
	end
	initial begin
		repeat (8000) @(negedge clk);
		n_errors++;
		complete_run();
	end
endmodule : rbhw_bench
